// ==== hw/ptp_state_pkg.sv ====
// constants, types and register map for the time-sync port state control block
// Overview of operation
// [R1] three modes: off, automatic, slave-only
// [R2] slave-only mode never takes a master role
// [R3] refuse mode off while multi-unit sync on
// [R4] report current port state continuously
// [R5] initializing: set up, transmit nothing
// [R6] one port initializing holds all initializing
// [R7] faulty: only required management replies sent
// [R8] faulty port activity stays on that port
// [R9] uncontained fault forces every port faulty
// [R10] disabled: send nothing, keep management only
// [R11] listening: wait announce or timeout, limited traffic
// [R12] pre-master: as master, limited traffic
// [R13] master: port is time source
// [R14] uncalibrated after master selected, servo prepares
// [R15] slave: track selected master continuously
// [R16] grand master: best clock, automatic, prior master
// [R17] report error when any port errs
// [R18] identity: mac with fffe filler inserted
// [R19] servo status: unlocked, synchronizing, locked, n/a
// [R20] mode off: state disabled, servo n/a
package ptp_state_pkg;

	// structure
	localparam int NUM_PORTS = 2;
	localparam int ADDR_W = 8;

	// timing: port set-up time spent in initializing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int INIT_TIME_NS = 1000;
	localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_CNT_W = 9;

	// register byte offsets
	localparam logic [ADDR_W-1:0] MODE_OFFSET = 8'h00;
	localparam logic [ADDR_W-1:0] MULTI_OFFSET = 8'h04;
	localparam logic [ADDR_W-1:0] STATE_OFFSET = 8'h08;
	localparam logic [ADDR_W-1:0] PORTS_OFFSET = 8'h0c;
	localparam logic [ADDR_W-1:0] SERVO_OFFSET = 8'h10;
	localparam logic [ADDR_W-1:0] ID_LO_OFFSET = 8'h14;
	localparam logic [ADDR_W-1:0] ID_HI_OFFSET = 8'h18;
	localparam logic [ADDR_W-1:0] MAC_LO_OFFSET = 8'h1c;
	localparam logic [ADDR_W-1:0] MAC_HI_OFFSET = 8'h20;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h24;
	localparam logic [ADDR_W-1:0] EVENT_OFFSET = 8'h28;

	// field positions
	localparam int CTRL_RESTART_BIT = 0;
	localparam int EVENT_REFUSED_BIT = 0;
	localparam int EVENT_SPREAD_BIT = 1;
	localparam int PORT_FIELD_W = 4;

	// reset value and identity filler
	localparam logic [47:0] MAC_RESET = 48'h0;
	localparam logic [15:0] EUI_FILLER = 16'hfffe;

	// operating modes
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_AUTO = 2'h1,
		MODE_SLAVE_ONLY = 2'h2
	} sync_mode_type;

	// protocol port states
	typedef enum logic [3:0] {
		ST_INITIALIZING = 4'h0,
		ST_FAULTY = 4'h1,
		ST_DISABLED = 4'h2,
		ST_LISTENING = 4'h3,
		ST_PRE_MASTER = 4'h4,
		ST_MASTER = 4'h5,
		ST_PASSIVE = 4'h6,
		ST_UNCALIBRATED = 4'h7,
		ST_SLAVE = 4'h8,
		ST_GRAND_MASTER = 4'h9,
		ST_ERROR = 4'ha
	} port_state_type;

	// servo lock report
	typedef enum logic [1:0] {
		SERVO_UNLOCKED = 2'h0,
		SERVO_SYNCHRONIZING = 2'h1,
		SERVO_LOCKED = 2'h2,
		SERVO_NOT_APPLICABLE = 2'h3
	} servo_state_type;

	// best-master election outcome for one port
	typedef enum logic [1:0] {
		REC_NONE = 2'h0,
		REC_MASTER = 2'h1,
		REC_SLAVE = 2'h2,
		REC_PASSIVE = 2'h3
	} recommend_type;

	// message classes seen by the per-port gate
	typedef enum logic [2:0] {
		MSG_EVENT = 3'h0,
		MSG_GENERAL = 3'h1,
		MSG_PDELAY = 3'h2,
		MSG_SIGNALING = 3'h3,
		MSG_MGMT_REPLY = 3'h4,
		MSG_MGMT_OTHER = 3'h5
	} msg_class_type;

endpackage

// ==== hw/ptp_msg_gate.sv ====
// per-port gate that grants transmit and accepts receive by port state
`timescale 1ns/1ps
module ptp_msg_gate import ptp_state_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// current state of this port
	input wire port_state_type port_state,
	// transmit request
	input wire logic tx_req,
	input wire logic [2:0] tx_class,
	output logic tx_grant,
	// receive offer
	input wire logic rx_valid,
	input wire logic [2:0] rx_class,
	output logic rx_accept
);

	// which message classes a port may place on the wire in a given state
	function automatic logic tx_permitted(port_state_type st, logic [2:0] cls);
		logic limited;
		limited = (cls == MSG_PDELAY) || (cls == MSG_SIGNALING) || (cls == MSG_MGMT_REPLY);
		case (st)
			ST_INITIALIZING, ST_DISABLED: tx_permitted = 1'b0; // [R5] [R10]
			ST_FAULTY, ST_ERROR: tx_permitted = (cls == MSG_MGMT_REPLY); // [R7]
			ST_LISTENING, ST_PASSIVE: tx_permitted = limited; // [R11]
			ST_PRE_MASTER: tx_permitted = limited || (cls == MSG_MGMT_OTHER); // [R12]
			ST_MASTER, ST_GRAND_MASTER, ST_UNCALIBRATED, ST_SLAVE: tx_permitted = (cls <= MSG_MGMT_OTHER); // [R13]
			default: tx_permitted = 1'b0;
		endcase
	endfunction

	// one-cycle grant, one edge after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_grant <= 1'b0;
		end else begin
			tx_grant <= tx_req && tx_permitted(port_state, tx_class);
		end
	end

	// a disabled port keeps only management traffic; other states keep all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_accept <= 1'b0;
		end else if (port_state == ST_DISABLED) begin
			rx_accept <= rx_valid && ((rx_class == MSG_MGMT_REPLY) || (rx_class == MSG_MGMT_OTHER)); // [R10]
		end else begin
			rx_accept <= rx_valid;
		end
	end

endmodule

// ==== hw/ptp_port_state_control.sv ====
// time-sync mode selection, port state tracking and apb register file
`timescale 1ns/1ps
module ptp_port_state_control import ptp_state_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// protocol engine events, one bit per port; election result two bits per port, local_is_best shared
	input wire logic [NUM_PORTS-1:0] fault_detect,
	input wire logic [NUM_PORTS-1:0] fault_clear,
	input wire logic [NUM_PORTS-1:0] fault_uncontained,
	input wire logic [NUM_PORTS-1:0] error_cond,
	input wire logic [NUM_PORTS-1:0] announce_rx,
	input wire logic [NUM_PORTS-1:0] announce_timeout,
	input wire logic [NUM_PORTS-1:0] qualify_timeout,
	input wire logic [NUM_PORTS-1:0] state_decision,
	input wire logic [NUM_PORTS-1:0] master_selected,
	input wire logic [NUM_PORTS-1:0] sync_fault,
	input wire logic [1:0] bmc_recommend [NUM_PORTS],
	input wire logic local_is_best,
	// servo and remote master
	input wire logic servo_locked,
	input wire logic [47:0] remote_master_mac,
	// per-port message gating
	input wire logic [NUM_PORTS-1:0] tx_req,
	input wire logic [2:0] tx_class [NUM_PORTS],
	output logic [NUM_PORTS-1:0] tx_grant,
	input wire logic [NUM_PORTS-1:0] rx_valid,
	input wire logic [2:0] rx_class [NUM_PORTS],
	output logic [NUM_PORTS-1:0] rx_accept,
	// status
	output logic [3:0] port_state_report,
	output logic [1:0] servo_lock_state,
	output logic [63:0] best_master_identity
);

	// software-visible configuration
	sync_mode_type timesync_mode_select_reg; // operating mode
	logic [1:0] multi_unit_sync_mode_reg; // non-zero blocks mode off
	logic [47:0] local_mac_reg; // own hardware address
	logic refused_reg; // sticky: a mode write was refused
	logic spread_seen_reg; // sticky: a fault spread to all ports
	// port state machines
	port_state_type port_state_reg [NUM_PORTS];
	port_state_type port_state_next [NUM_PORTS];
	// shared sequencing
	logic [INIT_CNT_W-1:0] init_cnt_reg; // remaining set-up cycles
	logic init_busy; // shared set-up period still running
	logic restart_req; // start a fresh set-up period
	logic all_faulty_reg; // every port forced faulty
	logic prior_master_reg; // another clock has been master
	sync_mode_type mode_prev_reg; // to spot leaving off
	// apb decode
	logic setup_phase;
	logic wr_fire;
	logic mode_wr;
	logic mode_wr_refused;
	logic addr_ok;
	logic [31:0] read_data;
	logic any_error;

	// bus helpers
	assign setup_phase = psel && !penable;
	assign wr_fire = psel && penable && pready && pwrite;

	// address check used for both reads and writes
	function automatic logic mapped(logic [ADDR_W-1:0] a);
		mapped = (a == MODE_OFFSET) || (a == MULTI_OFFSET) || (a == STATE_OFFSET) ||
			(a == PORTS_OFFSET) || (a == SERVO_OFFSET) || (a == ID_LO_OFFSET) ||
			(a == ID_HI_OFFSET) || (a == MAC_LO_OFFSET) || (a == MAC_HI_OFFSET) ||
			(a == CTRL_OFFSET) || (a == EVENT_OFFSET);
	endfunction

	// expand a 48-bit address into a 64-bit identity
	function automatic logic [63:0] eui64(logic [47:0] mac);
		eui64 = {mac[47:24], EUI_FILLER, mac[23:0]}; // [R18]
	endfunction

	// a mode write is refused for an unknown code, or off while multi-unit runs
	assign mode_wr = wr_fire && (paddr == MODE_OFFSET);
	assign mode_wr_refused = (pwdata[1:0] == 2'h3) ||
		((pwdata[1:0] == MODE_OFF) && (multi_unit_sync_mode_reg != 2'h0)); // [R3]
	assign addr_ok = mapped(paddr);

	// mode register; a refused write leaves it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timesync_mode_select_reg <= MODE_OFF;
		end else if (mode_wr && !mode_wr_refused) begin
			timesync_mode_select_reg <= sync_mode_type'(pwdata[1:0]); // [R1] [R3]
		end
	end

	// remaining configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			multi_unit_sync_mode_reg <= 2'h0;
			local_mac_reg <= MAC_RESET;
		end else if (wr_fire) begin
			if (paddr == MULTI_OFFSET) begin
				multi_unit_sync_mode_reg <= pwdata[1:0];
			end else if (paddr == MAC_LO_OFFSET) begin
				local_mac_reg[31:0] <= pwdata;
			end else if (paddr == MAC_HI_OFFSET) begin
				local_mac_reg[47:32] <= pwdata[15:0];
			end
		end
	end

	// sticky event bits: a new event in the clearing cycle wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused_reg <= 1'b0;
			spread_seen_reg <= 1'b0;
		end else begin
			if (mode_wr && mode_wr_refused) begin
				refused_reg <= 1'b1;
			end else if (wr_fire && (paddr == EVENT_OFFSET) && pwdata[EVENT_REFUSED_BIT]) begin
				refused_reg <= 1'b0;
			end
			if (|fault_uncontained) begin
				spread_seen_reg <= 1'b1;
			end else if (wr_fire && (paddr == EVENT_OFFSET) && pwdata[EVENT_SPREAD_BIT]) begin
				spread_seen_reg <= 1'b0;
			end
		end
	end

	// restart sources: software, a cleared fault, leaving mode off
	assign restart_req = (wr_fire && (paddr == CTRL_OFFSET) && pwdata[CTRL_RESTART_BIT]) ||
		(|fault_clear) || ((mode_prev_reg == MODE_OFF) && (timesync_mode_select_reg != MODE_OFF));

	// one shared set-up timer so every port stays initializing together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_reg <= INIT_CNT_W'(INIT_CYCLES);
			mode_prev_reg <= MODE_OFF;
		end else begin
			mode_prev_reg <= timesync_mode_select_reg;
			if (restart_req) begin
				init_cnt_reg <= INIT_CNT_W'(INIT_CYCLES); // [R6]
			end else if (init_cnt_reg != '0) begin
				init_cnt_reg <= init_cnt_reg - 1'b1;
			end
		end
	end
	assign init_busy = (init_cnt_reg != '0) || restart_req;

	// an uncontainable fault forces all ports faulty until a fault clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			all_faulty_reg <= 1'b0;
		end else if (|fault_uncontained) begin
			all_faulty_reg <= 1'b1; // [R9]
		end else if (|fault_clear) begin
			all_faulty_reg <= 1'b0;
		end
	end

	// remember that some other clock has served as master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prior_master_reg <= 1'b0;
		end else if (|announce_rx) begin
			prior_master_reg <= 1'b1;
		end
	end

	// election outcome applied from any settled state
	function automatic port_state_type decide(port_state_type cur, logic [1:0] rec);
		case (recommend_type'(rec))
			REC_MASTER: decide = (cur == ST_MASTER || cur == ST_GRAND_MASTER) ? cur : ST_PRE_MASTER;
			REC_SLAVE: decide = (cur == ST_SLAVE) ? cur : ST_UNCALIBRATED; // [R14]
			REC_PASSIVE: decide = ST_PASSIVE;
			default: decide = cur;
		endcase
	endfunction

	// per-port state machines and message gates
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			// next state, highest priority first
			always_comb begin
				port_state_next[gi] = port_state_reg[gi];
				if (timesync_mode_select_reg == MODE_OFF) begin
					port_state_next[gi] = ST_DISABLED; // [R20]
				end else if (init_busy) begin
					port_state_next[gi] = ST_INITIALIZING; // [R5] [R6]
				end else if (all_faulty_reg) begin
					port_state_next[gi] = ST_FAULTY; // [R9]
				end else if (fault_detect[gi]) begin
					port_state_next[gi] = ST_FAULTY; // [R8]
				end else if (error_cond[gi]) begin
					port_state_next[gi] = ST_ERROR; // [R17]
				end else begin
					case (port_state_reg[gi])
						ST_INITIALIZING: port_state_next[gi] = ST_LISTENING;
						ST_DISABLED: port_state_next[gi] = ST_LISTENING;
						ST_ERROR: port_state_next[gi] = ST_LISTENING;
						ST_FAULTY: port_state_next[gi] = ST_FAULTY; // left by a restart, mode off or an error condition
						ST_LISTENING: begin
							// wait for an election result or the announce timeout
							if (state_decision[gi]) begin
								port_state_next[gi] = decide(ST_LISTENING, bmc_recommend[gi]); // [R11]
							end else if (announce_timeout[gi]) begin
								port_state_next[gi] = ST_PRE_MASTER; // [R11]
							end
						end
						ST_PRE_MASTER: begin
							if (state_decision[gi]) begin
								port_state_next[gi] = decide(ST_PRE_MASTER, bmc_recommend[gi]);
							end else if (qualify_timeout[gi]) begin
								if (local_is_best && prior_master_reg &&
									timesync_mode_select_reg == MODE_AUTO) begin
									port_state_next[gi] = ST_GRAND_MASTER; // [R16]
								end else begin
									port_state_next[gi] = ST_MASTER; // [R12] [R13]
								end
							end
						end
						ST_UNCALIBRATED: begin
							if (state_decision[gi]) begin
								port_state_next[gi] = decide(ST_UNCALIBRATED, bmc_recommend[gi]);
							end else if (master_selected[gi]) begin
								port_state_next[gi] = ST_SLAVE; // [R14]
							end
						end
						ST_SLAVE: begin
							if (sync_fault[gi]) begin
								port_state_next[gi] = ST_UNCALIBRATED;
							end else if (state_decision[gi]) begin
								port_state_next[gi] = decide(ST_SLAVE, bmc_recommend[gi]); // [R15]
							end
						end
						default: begin
							// master, grand master, passive follow the election
							if (state_decision[gi]) begin
								port_state_next[gi] = decide(port_state_reg[gi], bmc_recommend[gi]);
							end
						end
					endcase
					// slave-only never lets a master role through
					if (timesync_mode_select_reg == MODE_SLAVE_ONLY &&
						(port_state_next[gi] == ST_PRE_MASTER || port_state_next[gi] == ST_MASTER ||
						port_state_next[gi] == ST_GRAND_MASTER)) begin
						port_state_next[gi] = ST_LISTENING; // [R2]
					end
				end
			end

			// state register
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_state_reg[gi] <= ST_INITIALIZING;
				end else begin
					port_state_reg[gi] <= port_state_next[gi];
				end
			end

			// message gate for this port; faults here touch no other port
			ptp_msg_gate u_gate (
				.pclk(pclk),
				.presetn(presetn),
				.port_state(port_state_reg[gi]),
				.tx_req(tx_req[gi]),
				.tx_class(tx_class[gi]),
				.tx_grant(tx_grant[gi]),
				.rx_valid(rx_valid[gi]),
				.rx_class(rx_class[gi]),
				.rx_accept(rx_accept[gi])
			);
		end
	endgenerate

	// any port in error shows the device-level error state
	always_comb begin
		any_error = 1'b0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			any_error = any_error || (port_state_reg[i] == ST_ERROR);
		end
	end

	// status outputs, refreshed every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_state_report <= ST_DISABLED;
			servo_lock_state <= SERVO_NOT_APPLICABLE;
			best_master_identity <= '0;
		end else begin
			if (mode_prev_reg == MODE_OFF && timesync_mode_select_reg == MODE_OFF) begin
				port_state_report <= ST_DISABLED; // [R20]
			end else if (any_error) begin
				port_state_report <= ST_ERROR; // [R17]
			end else begin
				port_state_report <= port_state_reg[0]; // [R4]
			end
			if (timesync_mode_select_reg == MODE_OFF) begin
				servo_lock_state <= SERVO_NOT_APPLICABLE; // [R20]
			end else if (port_state_reg[0] == ST_SLAVE) begin
				servo_lock_state <= servo_locked ? SERVO_LOCKED : SERVO_SYNCHRONIZING; // [R19]
			end else if (port_state_reg[0] == ST_UNCALIBRATED) begin
				servo_lock_state <= SERVO_UNLOCKED; // [R19]
			end else begin
				servo_lock_state <= SERVO_NOT_APPLICABLE;
			end
			// port 0 following names the remote master, otherwise ourselves
			if (port_state_reg[0] == ST_SLAVE || port_state_reg[0] == ST_UNCALIBRATED) begin
				best_master_identity <= eui64(remote_master_mac); // [R18]
			end else begin
				best_master_identity <= eui64(local_mac_reg); // [R18]
			end
		end
	end

	// read multiplexer
	always_comb begin
		read_data = 32'h0;
		if (paddr == MODE_OFFSET) begin
			read_data[1:0] = timesync_mode_select_reg;
		end else if (paddr == MULTI_OFFSET) begin
			read_data[1:0] = multi_unit_sync_mode_reg;
		end else if (paddr == STATE_OFFSET) begin
			read_data[3:0] = port_state_report;
		end else if (paddr == PORTS_OFFSET) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				read_data[i*PORT_FIELD_W +: PORT_FIELD_W] = port_state_reg[i];
			end
		end else if (paddr == SERVO_OFFSET) begin
			read_data[1:0] = servo_lock_state;
		end else if (paddr == ID_LO_OFFSET) begin
			read_data = best_master_identity[31:0];
		end else if (paddr == ID_HI_OFFSET) begin
			read_data = best_master_identity[63:32];
		end else if (paddr == MAC_LO_OFFSET) begin
			read_data = local_mac_reg[31:0];
		end else if (paddr == MAC_HI_OFFSET) begin
			read_data[15:0] = local_mac_reg[47:32];
		end else if (paddr == EVENT_OFFSET) begin
			read_data[EVENT_REFUSED_BIT] = refused_reg;
			read_data[EVENT_SPREAD_BIT] = spread_seen_reg;
		end
	end

	// apb answer: ready one cycle after setup, so no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup_phase;
			if (setup_phase) begin
				// refused mode writes and unmapped addresses both answer with an error
				pslverr <= !addr_ok || (pwrite && (paddr == MODE_OFFSET) && mode_wr_refused); // [R3]
				prdata <= pwrite ? 32'h0 : read_data;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

endmodule

// ==== dv/ptp_state_properties.sv ====
// concurrent checks on the port state control block's outputs
`timescale 1ns/1ps
module ptp_state_checker import ptp_state_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// gate traffic
	input wire logic [2:0] tx_class [NUM_PORTS],
	input wire logic [NUM_PORTS-1:0] tx_grant,
	input wire logic [2:0] rx_class [NUM_PORTS],
	input wire logic [NUM_PORTS-1:0] rx_accept,
	// status
	input wire logic [3:0] port_state_report,
	input wire logic [63:0] best_master_identity
);
	// one domain, so clock and reset are given once
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// grant and report follow one port register
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("setup without answer");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	init_silent_a: assert property (tx_grant[0] |-> port_state_report != ST_INITIALIZING)
		else $error("grant while initializing");
	off_silent_a: assert property (tx_grant[0] |-> port_state_report != ST_DISABLED)
		else $error("grant while disabled");
	faulty_reply_a: assert property (tx_grant[0] && port_state_report == ST_FAULTY |-> $past(tx_class[0]) == 3'h4)
		else $error("faulty non-reply");
	listen_limit_a: assert property (tx_grant[0] && port_state_report == ST_LISTENING
		|-> $past(tx_class[0]) inside {[3'h2:3'h4]})
		else $error("listening class");
	premaster_limit_a: assert property (tx_grant[0] && port_state_report == ST_PRE_MASTER
		|-> $past(tx_class[0]) inside {[3'h2:3'h5]})
		else $error("pre-master class");
	off_rx_a: assert property (rx_accept[0] && port_state_report == ST_DISABLED |-> $past(rx_class[0]) >= 3'h4)
		else $error("disabled rx class");
	eui_filler_a: assert property (best_master_identity != '0 |-> best_master_identity[39:24] == 16'hfffe)
		else $error("identity filler wrong");
	state_code_a: assert property (port_state_report <= 4'ha)
		else $error("bad state code");
endmodule
bind ptp_port_state_control ptp_state_checker ptp_state_checker_inst (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .tx_class, .tx_grant, .rx_class, .rx_accept, .port_state_report, .best_master_identity);

// ==== dv/ptp_peer_model.sv ====
// far-side clock model: raises protocol event pulses toward the block
`timescale 1ns/1ps
module ptp_peer_model import ptp_state_pkg::*; (
	// clock
	input wire logic pclk,
	// event pulses, one bit per port
	output logic [NUM_PORTS-1:0] announce_rx,
	output logic [NUM_PORTS-1:0] announce_timeout,
	output logic [NUM_PORTS-1:0] qualify_timeout,
	output logic [NUM_PORTS-1:0] state_decision,
	output logic [NUM_PORTS-1:0] master_selected,
	output logic [NUM_PORTS-1:0] sync_fault,
	// address of the remote master
	output logic [47:0] remote_master_mac
);
	localparam logic [47:0] PEER_MAC = 48'h0a1b_2c3d_4e5f; // arbitrary value
	logic [NUM_PORTS-1:0] ev [6] = '{default: '0}; // one slot per event kind
	assign {sync_fault, master_selected, state_decision, qualify_timeout, announce_timeout, announce_rx} =
		{ev[5], ev[4], ev[3], ev[2], ev[1], ev[0]};
	assign remote_master_mac = PEER_MAC;
	// each event is a one-cycle pulse
	task automatic send(input int kind, input logic [NUM_PORTS-1:0] ports);
		@(posedge pclk);
		ev[kind] <= ports;
		@(posedge pclk);
		ev[kind] <= '0;
	endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the port state control block
`timescale 1ns/1ps
module tb import ptp_state_pkg::*;;
	localparam int ANN = 0, ATO = 1, QTO = 2, DEC = 3, SEL = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic local_is_best = 0, servo_locked = 0, rnd_on = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [1:0] fault_detect = '0, fault_clear = '0, fault_uncontained = '0, error_cond = '0;
	logic [1:0] tx_req = '0, rx_valid = '0, tx_grant, rx_accept, g, a, servo_lock_state;
	logic [1:0] announce_rx, announce_timeout, qualify_timeout, state_decision, master_selected, sync_fault;
	logic [1:0] bmc_recommend [2] = '{default: '0};
	logic [2:0] tx_class [2] = '{default: '0}, rx_class [2] = '{default: '0};
	logic [3:0] port_state_report;
	logic [47:0] remote_master_mac;
	logic [63:0] best_master_identity;
	int fail_count = 0, checks_done = 0, seed = 47;
	ptp_port_state_control ptp_port_state_control_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .fault_detect, .fault_clear, .fault_uncontained, .error_cond,
		.announce_rx, .announce_timeout, .qualify_timeout, .state_decision, .master_selected, .sync_fault,
		.bmc_recommend, .local_is_best, .servo_locked, .remote_master_mac, .tx_req, .tx_class, .tx_grant,
		.rx_valid, .rx_class, .rx_accept, .port_state_report, .servo_lock_state, .best_master_identity);
	ptp_peer_model ptp_peer_model_inst (.pclk, .announce_rx, .announce_timeout, .qualify_timeout,
		.state_decision, .master_selected, .sync_fault, .remote_master_mac);
	// free-running clock
	initial forever #2.5 pclk = ~pclk;
	// random gate traffic feeds the checker
	always @(posedge pclk) if (rnd_on) begin
		tx_req <= 2'($random(seed));
		rx_valid <= 2'($random(seed));
		for (int i = 0; i < 2; i++) begin
			tx_class[i] <= 3'($unsigned($random(seed)) % 6);
			rx_class[i] <= 3'($unsigned($random(seed)) % 6);
		end
	end
	// expected state after a timeout event
	function automatic port_state_type after_event(int k, sync_mode_type m, logic best, logic seen);
		if (m == MODE_SLAVE_ONLY) return ST_LISTENING;
		if (k == ATO) return ST_PRE_MASTER;
		return (best && seen && m == MODE_AUTO) ? ST_GRAND_MASTER : ST_MASTER;
	endfunction
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, waits for ready
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic expect_state(input port_state_type exp, input int limit);
		for (int n = 0; n < limit && port_state_report !== exp; n++) @(posedge pclk);
		check("port state", port_state_report, exp);
	endtask
	// class c on both ports, result one edge later
	task automatic probe(input logic [2:0] c);
		rnd_on = 0;
		@(posedge pclk);
		tx_req <= 2'b11;
		rx_valid <= 2'b11;
		tx_class <= '{c, c};
		rx_class <= '{c, c};
		@(posedge pclk);
		tx_req <= '0;
		rx_valid <= '0;
		@(posedge pclk);
		g = tx_grant;
		a = rx_accept;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (6000) @(posedge pclk);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		check("reset state", port_state_report, ST_DISABLED);
		check("reset servo", servo_lock_state, SERVO_NOT_APPLICABLE);
		for (int m = 1; m < 4; m++) begin
			apb(1, MODE_OFFSET, m);
			check("mode err", er, m == 3);
			apb(0, MODE_OFFSET, 0);
			check("mode", rd, m == 3 ? 2 : m);
		end
		apb(1, MODE_OFFSET, MODE_OFF);
		apb(0, 8'h3c, 0);
		check("unmapped err", er, 1);
		check("unmapped data", rd, 0);
		$display("test modes done");
		rnd_on = 1;
		apb(1, MODE_OFFSET, MODE_AUTO);
		apb(1, MULTI_OFFSET, 1);
		apb(1, MODE_OFFSET, MODE_OFF);
		check("off refused", er, 1);
		apb(0, MODE_OFFSET, 0);
		check("mode kept", rd, MODE_AUTO);
		apb(0, EVENT_OFFSET, 0);
		check("refused flag", rd[EVENT_REFUSED_BIT], 1);
		apb(1, MULTI_OFFSET, 0);
		expect_state(ST_INITIALIZING, 4);
		expect_state(ST_LISTENING, 260);
		ptp_peer_model_inst.send(ANN, 2'b11);
		local_is_best <= 1;
		for (int k = ATO; k <= QTO; k++) begin
			ptp_peer_model_inst.send(k, 2'b01);
			expect_state(after_event(k, MODE_AUTO, 1, 1), 6);
		end
		probe(MSG_EVENT);
		check("gm event grant", g[0], 1);
		bmc_recommend[0] <= REC_SLAVE;
		servo_locked <= 1;
		ptp_peer_model_inst.send(DEC, 2'b01);
		expect_state(ST_UNCALIBRATED, 6);
		ptp_peer_model_inst.send(SEL, 2'b01);
		expect_state(ST_SLAVE, 6);
		check("servo", servo_lock_state, SERVO_LOCKED);
		check("identity", best_master_identity,
			{remote_master_mac[47:24], 16'hfffe, remote_master_mac[23:0]});
		$display("test election done");
		fault_detect <= 2'b10;
		apb(0, PORTS_OFFSET, 0);
		check("one faulty", rd[7:0], 8'h18);
		fault_detect <= '0;
		fault_uncontained <= 2'b10;
		@(posedge pclk);
		fault_uncontained <= '0;
		expect_state(ST_FAULTY, 6);
		apb(0, PORTS_OFFSET, 0);
		check("all faulty", rd[7:0], 8'h11);
		for (int c = 0; c < 6; c++) begin
			probe(c);
			check("faulty grant", g, c == 4 ? 2'b11 : 2'b00);
		end
		rnd_on = 1;
		fault_clear <= 2'b01;
		@(posedge pclk);
		fault_clear <= '0;
		expect_state(ST_INITIALIZING, 6);
		apb(0, PORTS_OFFSET, 0);
		check("all init", rd[7:0], 8'h00);
		expect_state(ST_LISTENING, 260);
		error_cond <= 2'b10;
		expect_state(ST_ERROR, 6);
		error_cond <= '0;
		expect_state(ST_LISTENING, 6);
		$display("test faults done");
		apb(1, MODE_OFFSET, MODE_OFF);
		expect_state(ST_DISABLED, 6);
		check("off servo", servo_lock_state, SERVO_NOT_APPLICABLE);
		for (int c = 0; c < 6; c++) begin
			probe(c);
			check("off accept", {g, a}, c >= 4 ? 4'h3 : 4'h0);
		end
		rnd_on = 1;
		apb(1, MODE_OFFSET, MODE_SLAVE_ONLY);
		expect_state(ST_LISTENING, 260);
		bmc_recommend[0] <= REC_MASTER;
		for (int k = ATO; k <= DEC; k++) begin
			ptp_peer_model_inst.send(k, 2'b01);
			repeat (4) @(posedge pclk);
			expect_state(after_event(k, MODE_SLAVE_ONLY, 1, 1), 0);
		end
		$display("test slave only done");
		wrap_up();
	end
endmodule
